// ### src/ubtc_pkg.sv
// shared register map, field layout and constants of the baud and rx/tx control block
package ubtc_pkg;
	localparam logic [7:0] CMD_OFFS = 8'h00;
	localparam logic [7:0] MODE_OFFS = 8'h04;
	localparam logic [7:0] DIV_OFFS = 8'h20;
	localparam logic [7:0] RATIO_OFFS = 8'h40;
	localparam logic [7:0] STAT_OFFS = 8'h14;
	localparam int CMD_RX_SOFT_RESET_CMD_BIT = 2;
	localparam int CMD_TX_SOFT_RESET_CMD_BIT = 3;
	localparam int CMD_RX_ENABLE_CMD_BIT = 4;
	localparam int CMD_RX_DISABLE_CMD_BIT = 5;
	localparam int CMD_TX_ENABLE_CMD_BIT = 6;
	localparam int CMD_TX_DISABLE_CMD_BIT = 7;
	localparam int MODE_SMODE_LSB = 0;
	localparam int MODE_CLKSEL_LSB = 4;
	localparam int MODE_SYNC_BIT = 8;
	localparam int MODE_OVER_BIT = 19;
	localparam int MODE_CLK_OUT_ENABLE_BIT = 18;
	localparam int DIV_FRAC_LSB = 16;
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [15:0] INT_DIV_RST = 16'h0000;
	localparam logic [2:0] FRAC_RST = 3'h0;
	localparam logic [10:0] CARD_RATIO_RST = 11'h174;
	localparam logic [3:0] SMODE_NORMAL = 4'h0;
	localparam logic [3:0] SMODE_ISO_T0 = 4'h4;
	localparam logic [3:0] SMODE_ISO_T1 = 4'h6;
	localparam logic [1:0] CLKSEL_MCK = 2'h0;
	localparam logic [1:0] CLKSEL_DIV = 2'h1;
	localparam logic [1:0] CLKSEL_EXT = 2'h3;
	localparam int PRESCALE = 8;
	typedef struct packed {
		logic rxEnabled;
		logic txEnabled;
		logic rxBusy;
		logic txBusy;
		logic txHoldFull;
	} ubtc_status_s;
	// rate adjust code to divider factor, zero for unlisted codes
	function automatic logic [5:0] ubtc_rate_adjust(input logic [3:0] code);
		unique case (code)
			4'h1: return 6'h01;
			4'h2: return 6'h02;
			4'h3: return 6'h04;
			4'h4: return 6'h08;
			4'h5: return 6'h10;
			4'h6: return 6'h20;
			4'h8: return 6'h0c;
			4'h9: return 6'h14;
			default: return 6'h00;
		endcase
	endfunction
	function automatic logic [11:0] ubtc_clk_division(input logic [3:0] code);
		unique case (code)
			4'h0, 4'h1: return 12'h174;
			4'h2: return 12'h22e;
			4'h3: return 12'h2e8;
			4'h4: return 12'h45c;
			4'h5: return 12'h5d0;
			4'h6: return 12'h744;
			4'h9: return 12'h200;
			4'ha: return 12'h300;
			4'hb: return 12'h400;
			4'hc: return 12'h600;
			4'hd: return 12'h800;
			default: return 12'h000;
		endcase
	endfunction
endpackage

// ### src/ubtc_usart_baud_and_txrx_control.sv
// baud generator (async, fractional, sync, smart card) and rx/tx enable control with apb slave
`timescale 1ns/1ps
module ubtc_usart_baud_and_txrx_control #(
	parameter int DIV_WIDTH = 16,
	parameter int RATIO_WIDTH = 11
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	output logic baudTick,
	output logic sampleTick,
	output logic etuTick,
	output logic rxEnabled,
	output logic txEnabled,
	output logic rxSoftReset,
	output logic txSoftReset,
	input wire logic rxBusy,
	input wire logic txBusy,
	input wire logic txHoldFull
);
	initial begin
		if (DIV_WIDTH != 16 || RATIO_WIDTH != 11) $error("unsupported divider widths");
	end

	logic [31:0] mode_q;
	logic [DIV_WIDTH-1:0] intDiv_q;
	logic [2:0] frac_q;
	logic [RATIO_WIDTH-1:0] cardRatio_q;
	logic rx_enable_cmd_q, tx_enable_cmd_q, rxDisPend_q, txDisPend_q;
	logic rxRst_q, txRst_q;
	logic sck1_q, sck2_q, sck3_q;
	logic [2:0] pre_q;
	logic [DIV_WIDTH:0] divCnt_q;
	logic [2:0] fracAcc_q;
	logic divOut_q, divTick;
	logic half_q;
	logic [4:0] ovs_q;
	logic [RATIO_WIDTH-1:0] etuCnt_q;
	logic srcTick, wrAcc;
	logic [3:0] smode;
	logic [1:0] clkSel;
	logic syncMode, over, cardMode;
	ubtc_pkg::ubtc_status_s stat;

	assign smode = mode_q[ubtc_pkg::MODE_SMODE_LSB +: 4];
	assign clkSel = mode_q[ubtc_pkg::MODE_CLKSEL_LSB +: 2];
	assign syncMode = mode_q[ubtc_pkg::MODE_SYNC_BIT];
	assign over = mode_q[ubtc_pkg::MODE_OVER_BIT];
	assign cardMode = (smode == ubtc_pkg::SMODE_ISO_T0) || (smode == ubtc_pkg::SMODE_ISO_T1);
	assign wrAcc = psel && penable && pwrite;

	// apb: zero wait states, unmapped addresses read zero and answer with an error
	assign pready = 1'b1;
	always_comb begin
		pslverr = 1'b0;
		prdata = 32'h0000_0000;
		stat = '{rx_enable_cmd_q, tx_enable_cmd_q, rxBusy, txBusy, txHoldFull};
		unique case (paddr)
			ubtc_pkg::CMD_OFFS: prdata = 32'h0000_0000;
			ubtc_pkg::MODE_OFFS: prdata = mode_q;
			ubtc_pkg::DIV_OFFS: prdata = {13'h0000, frac_q, intDiv_q};
			ubtc_pkg::RATIO_OFFS: prdata = {21'h00_0000, cardRatio_q};
			ubtc_pkg::STAT_OFFS: prdata = {27'h000_0000, stat};
			default: pslverr = psel && penable;
		endcase
	end

	// configuration survives soft resets, only srst reloads it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mode_q <= ubtc_pkg::MODE_RST;
			intDiv_q <= ubtc_pkg::INT_DIV_RST;
			frac_q <= ubtc_pkg::FRAC_RST;
			cardRatio_q <= ubtc_pkg::CARD_RATIO_RST;
		end else if (wrAcc) begin
			if (paddr == ubtc_pkg::MODE_OFFS) mode_q <= pwdata;
			if (paddr == ubtc_pkg::DIV_OFFS) begin
				intDiv_q <= pwdata[DIV_WIDTH-1:0];
				frac_q <= pwdata[ubtc_pkg::DIV_FRAC_LSB +: 3];
			end
			if (paddr == ubtc_pkg::RATIO_OFFS) cardRatio_q <= pwdata[RATIO_WIDTH-1:0];
		end
	end

	// command pulses; zero bits do nothing, disable beats enable
	logic cmdWr;
	assign cmdWr = wrAcc && (paddr == ubtc_pkg::CMD_OFFS);
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rxRst_q <= 1'b0;
			txRst_q <= 1'b0;
		end else begin
			rxRst_q <= cmdWr && pwdata[ubtc_pkg::CMD_RX_SOFT_RESET_CMD_BIT];
			txRst_q <= cmdWr && pwdata[ubtc_pkg::CMD_TX_SOFT_RESET_CMD_BIT];
		end
	end
	assign rxSoftReset = rxRst_q;
	assign txSoftReset = txRst_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_enable_cmd_q <= 1'b0;
			rxDisPend_q <= 1'b0;
		end else if (cmdWr && pwdata[ubtc_pkg::CMD_RX_DISABLE_CMD_BIT]) begin
			rxDisPend_q <= rx_enable_cmd_q;
		end else if (cmdWr && pwdata[ubtc_pkg::CMD_RX_ENABLE_CMD_BIT]) begin
			rx_enable_cmd_q <= 1'b1;
			rxDisPend_q <= 1'b0;
		end else if (rxDisPend_q && !rxBusy) begin
			rx_enable_cmd_q <= 1'b0;
			rxDisPend_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			tx_enable_cmd_q <= 1'b0;
			txDisPend_q <= 1'b0;
		end else if (cmdWr && pwdata[ubtc_pkg::CMD_TX_DISABLE_CMD_BIT]) begin
			txDisPend_q <= tx_enable_cmd_q;
		end else if (cmdWr && pwdata[ubtc_pkg::CMD_TX_ENABLE_CMD_BIT]) begin
			tx_enable_cmd_q <= 1'b1;
			txDisPend_q <= 1'b0;
		end else if (txDisPend_q && !txBusy && !txHoldFull) begin
			tx_enable_cmd_q <= 1'b0;
			txDisPend_q <= 1'b0;
		end
	end
	assign rxEnabled = rx_enable_cmd_q;
	assign txEnabled = tx_enable_cmd_q;

	// external clock synchronised before edge detection
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sck1_q <= 1'b0;
			sck2_q <= 1'b0;
			sck3_q <= 1'b0;
		end else begin
			sck1_q <= sckIn;
			sck2_q <= sck1_q;
			sck3_q <= sck2_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) pre_q <= 3'h0;
		else pre_q <= pre_q + 3'h1;
	end

	// source select: master clock, master/8, or rising edge of external pin
	always_comb begin
		unique case (clkSel)
			ubtc_pkg::CLKSEL_DIV: srcTick = (pre_q == 3'(ubtc_pkg::PRESCALE - 1));
			ubtc_pkg::CLKSEL_EXT: srcTick = sck2_q && !sck3_q;
			default: srcTick = 1'b1;
		endcase
	end

	// main divider; counts source ticks, extra tick every eighth of frac when enabled
	logic fracOn;
	logic [DIV_WIDTH:0] divLimit;
	logic [3:0] fracSum;
	assign fracOn = (frac_q != 3'h0) && (smode == ubtc_pkg::SMODE_NORMAL) && !syncMode;
	assign fracSum = {1'b0, fracAcc_q} + {1'b0, frac_q};
	assign divLimit = (fracOn && fracSum[3]) ? {1'b0, intDiv_q} + 17'h0_0001 : {1'b0, intDiv_q};
	always_ff @(posedge core_clk) begin
		if (srst) begin
			divCnt_q <= '0;
			fracAcc_q <= 3'h0;
		end else if (intDiv_q == '0) begin
			divCnt_q <= '0;
		end else if (srcTick) begin
			if (divCnt_q + 17'h0_0001 >= divLimit) begin
				divCnt_q <= '0;
				fracAcc_q <= fracOn ? fracSum[2:0] : 3'h0;
			end else begin
				divCnt_q <= divCnt_q + 17'h0_0001;
			end
		end
	end
	// divisor 1 bypasses while fracOn is low: every source tick passes
	assign divTick = srcTick && (intDiv_q != '0) && (divCnt_q + 17'h0_0001 >= divLimit);

	// sync-mode bit clock; external source is used straight, ignoring the divisor
	logic syncExt;
	assign syncExt = syncMode && (clkSel == ubtc_pkg::CLKSEL_EXT);
	logic halfPoint;
	// master-clock source toggles at both halves so odd divisors stay balanced
	assign halfPoint = (clkSel == ubtc_pkg::CLKSEL_MCK) && srcTick && (intDiv_q > 16'h0001)
		&& (divCnt_q + 17'h0_0001 == {2'b00, intDiv_q[DIV_WIDTH-1:1]});
	always_ff @(posedge core_clk) begin
		if (srst) begin
			half_q <= 1'b0;
			divOut_q <= 1'b0;
		end else begin
			if (divTick) half_q <= 1'b0;
			else if (halfPoint) half_q <= 1'b1;
			if (syncExt) divOut_q <= sck2_q;
			else if (intDiv_q == 16'h0001) divOut_q <= (clkSel == ubtc_pkg::CLKSEL_MCK) ? ~divOut_q : divTick;
			else if (clkSel == ubtc_pkg::CLKSEL_MCK) divOut_q <= halfPoint;
			else divOut_q <= (divCnt_q < {2'b00, intDiv_q[DIV_WIDTH-1:1]});
		end
	end

	// oversampling: async baud is divider output over 16 or 8
	always_ff @(posedge core_clk) begin
		if (srst || !(rx_enable_cmd_q || tx_enable_cmd_q) || syncMode || cardMode) ovs_q <= 5'h00;
		else if (divTick) ovs_q <= (ovs_q == (over ? 5'h07 : 5'h0f)) ? 5'h00 : ovs_q + 5'h01;
	end

	// card mode: sampling divider splits card clock into time units
	always_ff @(posedge core_clk) begin
		if (srst || !cardMode || cardRatio_q == '0) etuCnt_q <= '0;
		else if (divTick) etuCnt_q <= (etuCnt_q + 11'h001 >= cardRatio_q) ? '0 : etuCnt_q + 11'h001;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			baudTick <= 1'b0;
			sampleTick <= 1'b0;
			etuTick <= 1'b0;
		end else begin
			sampleTick <= divTick && !syncMode && !cardMode;
			etuTick <= divTick && cardMode && (etuCnt_q + 11'h001 >= cardRatio_q) && cardRatio_q != '0;
			if (cardMode) baudTick <= divTick && (etuCnt_q + 11'h001 >= cardRatio_q) && cardRatio_q != '0;
			else if (syncExt) baudTick <= sck2_q && !sck3_q;
			else if (syncMode) baudTick <= divTick;
			else baudTick <= divTick && (ovs_q == (over ? 5'h07 : 5'h0f));
		end
	end

	// serial clock pin: driven in sync mode with internal source, or in card mode with clock out
	logic sckLevel;
	assign sckLevel = (clkSel == ubtc_pkg::CLKSEL_MCK && intDiv_q != 16'h0001) ? (divOut_q ^ half_q) : divOut_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sckOut <= 1'b0;
			sckOe <= 1'b0;
		end else begin
			sckOe <= (syncMode && !syncExt) || (cardMode && mode_q[ubtc_pkg::MODE_CLK_OUT_ENABLE_BIT]);
			sckOut <= sckLevel;
		end
	end
endmodule

// ### tb/ubtc_partner.sv
// external serial clock source on the far side
`timescale 1ns/1ps
module ubtc_partner #(
	parameter int HALF = 5
) (
	input wire logic core_clk,
	input wire logic run,
	output logic sckIn
);
	int cnt;
	initial sckIn = 1'b0;
	// parked low outside bursts so a stale edge never leaks in
	always @(posedge core_clk) begin
		if (!run) begin
			cnt <= 0;
			sckIn <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			sckIn <= ~sckIn;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ### tb/ubtc_checker.sv
// port assertions for the baud and rx/tx control block
`timescale 1ns/1ps
module ubtc_checker (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxEnabled,
	input wire logic txEnabled,
	input wire logic rxSoftReset,
	input wire logic txSoftReset,
	input wire logic rxBusy,
	input wire logic txBusy,
	input wire logic txHoldFull
);
	logic [7:0] c;
	// command bits of an accepted write, zero otherwise
	assign c = (psel && penable && pready && pwrite && paddr == ubtc_pkg::CMD_OFFS) ? pwdata[7:0] : 8'h00;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_rx_enable_cmd; $rose(rxEnabled) |-> $past(c[4] && !c[5]); endproperty
	a_rx_enable_cmd: assert property (p_rx_enable_cmd) else $error("rx enabled without command");
	property p_tx_enable_cmd; $rose(txEnabled) |-> $past(c[6] && !c[7]); endproperty
	a_tx_enable_cmd: assert property (p_tx_enable_cmd) else $error("tx enabled without command");
	property p_dis; (c[4] && c[5] |=> !$rose(rxEnabled)) and (c[6] && c[7] |=> !$rose(txEnabled)); endproperty
	a_dis: assert property (p_dis) else $error("enable beat disable");
	property p_rxDrain; $fell(rxEnabled) && !rxSoftReset |-> !$past(rxBusy); endproperty
	a_rxDrain: assert property (p_rxDrain) else $error("rx stopped mid character");
	property p_txDrain; $fell(txEnabled) && !txSoftReset |-> !$past(txBusy) && !$past(txHoldFull); endproperty
	a_txDrain: assert property (p_txDrain) else $error("tx stopped with data left");
	property p_soft; rxSoftReset == $past(c[2]) && txSoftReset == $past(c[3]); endproperty
	a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
	property p_unmap; psel && penable && !(paddr inside {8'h00, 8'h04, 8'h14, 8'h20, 8'h40}) |-> pslverr && prdata == 0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule
bind ubtc_usart_baud_and_txrx_control ubtc_checker i_ubtc_checker (.core_clk, .srst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .rxEnabled, .txEnabled, .rxSoftReset, .txSoftReset, .rxBusy,
	.txBusy, .txHoldFull);

// ### tb/test_usart_baud_and_txrx_control.sv
// bench for the baud and rx/tx control block
`timescale 1ns/1ps
module test_usart_baud_and_txrx_control;
	logic core_clk, srst, psel, penable, pwrite, pready, pslverr, sckIn, sckOut, sckOe, sckRun, e;
	logic baudTick, sampleTick, etuTick, rxEnabled, txEnabled, rxSoftReset, txSoftReset, rxBusy, txBusy, txHoldFull;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] ticks;
	int error_cnt = 0;
	int cmp_count = 0;
	assign ticks = {etuTick, sampleTick, baudTick};
	ubtc_usart_baud_and_txrx_control i_ubtc_usart_baud_and_txrx_control (.core_clk, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sckIn, .sckOut, .sckOe, .baudTick, .sampleTick, .etuTick,
		.rxEnabled, .txEnabled, .rxSoftReset, .txSoftReset, .rxBusy, .txBusy, .txHoldFull);
	ubtc_partner i_ubtc_partner (.core_clk, .run(sckRun), .sckIn);
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100) begin
			chk("pready", 1, 0);
			test_done();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask
	// two idle edges let deferred enable changes land first
	task automatic st(input logic [31:0] exp);
		repeat (2) @(posedge core_clk);
		rdc("status", ubtc_pkg::STAT_OFFS, exp);
	endtask
	task automatic wt(input int sel, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (ticks[sel] !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			chk("tick wait", 0, 1);
			test_done();
		end
	endtask
	// first gap after a reprogram is ragged, so skip two ticks
	task automatic rate(input string what, input logic [31:0] mode, input logic [31:0] dv, input int sel, input int exp);
		int n;
		apb(1'b1, ubtc_pkg::MODE_OFFS, mode);
		apb(1'b1, ubtc_pkg::DIV_OFFS, dv);
		wt(sel, n);
		wt(sel, n);
		wt(sel, n);
		chk(what, exp, n);
	endtask
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		rxBusy = 1'b0;
		txBusy = 1'b0;
		txHoldFull = 1'b0;
		sckRun = 1'b0;
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		rdc("card ratio", ubtc_pkg::RATIO_OFFS, 32'h0000_0174);
		st(32'h0000_0000);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk("unmapped error", 1, e);
		$display("test reset done");
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0010);
		st(32'h0000_0010);
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0000);
		st(32'h0000_0010);
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_00c0);
		st(32'h0000_0010);
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0040);
		st(32'h0000_0018);
		rxBusy <= 1'b1;
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0020);
		st(32'h0000_001c);
		rxBusy <= 1'b0;
		st(32'h0000_0008);
		txHoldFull <= 1'b1;
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0080);
		st(32'h0000_0009);
		txHoldFull <= 1'b0;
		txBusy <= 1'b1;
		st(32'h0000_000a);
		txBusy <= 1'b0;
		st(32'h0000_0000);
		$display("test enable done");
		apb(1'b1, ubtc_pkg::MODE_OFFS, 32'h0008_0000);
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_000c);
		// pulse stands only until the next edge, so look right after the access edge
		#1;
		chk("rx soft reset", 1, rxSoftReset);
		chk("tx soft reset", 1, txSoftReset);
		rdc("mode kept", ubtc_pkg::MODE_OFFS, 32'h0008_0000);
		$display("test soft reset done");
		// oversampling counter only runs with a side enabled
		apb(1'b1, ubtc_pkg::CMD_OFFS, 32'h0000_0010);
		apb(1'b1, ubtc_pkg::RATIO_OFFS, 32'h0000_0003);
		rate("async x16", 32'h0000_0000, 32'h0000_0002, 0, 32);
		rate("async x8", 32'h0008_0000, 32'h0000_0003, 0, 24);
		rate("sample", 32'h0000_0000, 32'h0000_0003, 1, 3);
		rate("fraction", 32'h0008_0000, 32'h0003_0002, 0, 19);
		rate("prescaled", 32'h0000_0010, 32'h0000_0002, 0, 256);
		rate("sync", 32'h0000_0100, 32'h0000_0005, 0, 5);
		rate("bypass", 32'h0000_0100, 32'h0000_0001, 0, 1);
		sckRun <= 1'b1;
		rate("external", 32'h0000_0130, 32'h0000_0000, 0, 10);
		sckRun <= 1'b0;
		rate("card unit", 32'h0004_0004, 32'h0004_0002, 2, 6);
		chk("card clock enable", 1, sckOe);
		$display("test rates done");
		test_done();
	end
endmodule
